// [rtl/pgcs_regs.sv]
`timescale 1ns/10ps
//Contract
//- Writing control bit 15 resets device; bit reads 1 until reset done.
//- Control reset also returns the media access machine to initial state.
//- Bit 14 wraps transmit data internally, default 1; 0 uses network.
//- During wrap, network lines idle and access machine held initial.
//- Bit 11 power down: machine reset, tx/rx stopped, oscillator enable off.
//- While powered down, only the power-down bit accepts writes.
//- Bit 10 isolate: ignore MII tx inputs, tri-state MII outputs.
//- Bit 7 asserts collision whenever MII transmit enable is asserted.
//- Control bits 13,12,9,8 and 6..0 read as zero.
//- Status bits 15..5 and 3 read as zero.
//- Remote fault bit latches high until status is read.
//- Link bit latches low on link loss until status is read.
//- Jabber bit latches high until status is read.
//- Status bit 0 is always 1.
//- With ignore-link-pulses set link reads 1, else follows link pulses.
//- Unimplemented management addresses read all zeros.
module pgcs_regs
    import pgcs_pkg::*;
#(
    parameter logic [4:0]   PHY_ADDR     = 5'h00,
    parameter int           RESET_CYCLES = PGCS_RESET_CYCLES
)(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       management_clock,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    input  wire logic       ignore_link_pulses,
    input  wire logic       remote_fault_in,
    input  wire logic       link_pulses_ok,
    input  wire logic       jabber_in,
    input  wire logic       mii_tx_enable_in,
    input  wire logic [3:0] mii_tx_data_in,
    input  wire logic       mii_tx_error_in,
    input  wire logic       net_rx_valid_in,
    input  wire logic [3:0] net_rx_data_in,
    input  wire logic       net_collision_in,
    output logic            mii_tx_clock_out,
    output logic            mii_rx_clock_out,
    output logic            mii_rx_valid_out,
    output logic            mii_rx_error_out,
    output logic [3:0]      mii_rx_data_out,
    output logic            mii_collision_out,
    output logic            mii_out_oe,
    output logic            net_tx_enable_out,
    output logic [3:0]      net_tx_data_out,
    output logic            net_drive_en,
    output logic            oscillator_enable_out,
    output logic            mac_initial_state
);

    // Reset counter is eight bits wide
    if (RESET_CYCLES < 1 || RESET_CYCLES > 255)
    begin : g_bad_reset_cycles
        $error("RESET_CYCLES out of range");
    end

    localparam int          PIN_W = 16;
    localparam logic [7:0]  RST_LOAD = RESET_CYCLES[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Management clock domain: serial frame engine

    pgcs_md_state_t md_state_q;
    logic           prev_one_q;
    logic [3:0]     md_cnt_q;
    logic [11:0]    hdr_q;
    logic [15:0]    shift_q;
    logic [4:0]     waddr_q;
    logic [15:0]    wdata_q;
    logic           snap_tgl_q;
    logic           clr_tgl_q;
    logic           wr_tgl_q;
    logic           rd_act_q;
    logic [15:0]    snap_ctrl_q;
    logic [15:0]    snap_stat_q;
    logic [15:0]    rd_word;

    // Snapshot words reload a few ref_clk cycles after the start bits and then hold to the end of the frame, so sampling them here is safe
    function automatic logic [15:0] read_word(input logic [4:0] a, input logic [15:0] c, input logic [15:0] s);
        if (a == PGCS_ADDR_CTRL)
            return c;
        else if (a == PGCS_ADDR_STAT)
            return s;
        else
            return 16'h0000;
    endfunction

    assign rd_word = read_word(waddr_q, snap_ctrl_q, snap_stat_q);

    always_ff @(posedge management_clock)
    begin
        if (rst)
        begin
            md_state_q <= PGCS_MD_IDLE;
            prev_one_q <= 1'b0;
            md_cnt_q   <= 4'h0;
            hdr_q      <= 12'h000;
            shift_q    <= 16'h0000;
            waddr_q    <= 5'h00;
            wdata_q    <= 16'h0000;
            snap_tgl_q <= 1'b0;
            clr_tgl_q  <= 1'b0;
            wr_tgl_q   <= 1'b0;
            rd_act_q   <= 1'b0;
            mdio_out   <= 1'b0;
            mdio_oe    <= 1'b0;
        end
        else
        begin
            prev_one_q <= mdio_in;
            case (md_state_q)
                PGCS_MD_IDLE:
                begin
                    mdio_oe <= 1'b0;
                    if (prev_one_q && !mdio_in)
                        md_state_q <= PGCS_MD_START;
                end
                PGCS_MD_START:
                begin
                    md_cnt_q <= 4'h0;
                    if (mdio_in)
                    begin
                        snap_tgl_q <= ~snap_tgl_q;
                        md_state_q <= PGCS_MD_HDR;
                    end
                    else
                        md_state_q <= PGCS_MD_IDLE;
                end
                PGCS_MD_HDR:
                begin
                    hdr_q    <= {hdr_q[10:0], mdio_in};
                    md_cnt_q <= md_cnt_q + 4'h1;
                    if (md_cnt_q == PGCS_HDR_LAST)
                    begin
                        md_cnt_q   <= 4'h0;
                        md_state_q <= PGCS_MD_TA;
                        rd_act_q   <= (hdr_q[10:9] == PGCS_OP_READ) && (hdr_q[8:4] == PHY_ADDR);
                        waddr_q    <= {hdr_q[3:0], mdio_in};
                        if (hdr_q[10:9] != PGCS_OP_READ && hdr_q[10:9] != PGCS_OP_WRITE)
                            md_state_q <= PGCS_MD_IDLE;
                    end
                end
                PGCS_MD_TA:
                begin
                    md_cnt_q <= md_cnt_q + 4'h1;
                    if (md_cnt_q == 4'h0)
                    begin
                        mdio_oe  <= rd_act_q;
                        mdio_out <= 1'b0;
                    end
                    else
                    begin
                        md_cnt_q   <= 4'h0;
                        md_state_q <= PGCS_MD_DATA;
                        shift_q    <= rd_word;
                        mdio_out   <= rd_word[15];
                        if (rd_act_q && waddr_q == PGCS_ADDR_STAT)
                            clr_tgl_q <= ~clr_tgl_q;
                    end
                end
                PGCS_MD_DATA:
                begin
                    md_cnt_q <= md_cnt_q + 4'h1;
                    shift_q  <= rd_act_q ? {shift_q[14:0], 1'b0} : {shift_q[14:0], mdio_in};
                    mdio_out <= shift_q[14];
                    if (md_cnt_q == PGCS_DATA_LAST)
                    begin
                        md_state_q <= PGCS_MD_IDLE;
                        mdio_oe    <= 1'b0;
                        // Header has taken its last address bit by now
                        if (!rd_act_q && hdr_q[11:10] == PGCS_OP_WRITE && hdr_q[9:5] == PHY_ADDR)
                        begin
                            wdata_q  <= {shift_q[14:0], mdio_in};
                            wr_tgl_q <= ~wr_tgl_q;
                        end
                    end
                end
                default:
                    md_state_q <= PGCS_MD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossings into ref_clk: three event toggles and the pin inputs

    logic [2:0]       tgl_meta_q;
    logic [2:0]       tgl_sync_q;
    logic [2:0]       tgl_last_q;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;
    logic             snap_ev;
    logic             clr_ev;
    logic             wr_ev;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            tgl_meta_q <= 3'h0;
            tgl_sync_q <= 3'h0;
            tgl_last_q <= 3'h0;
            pin_meta_q <= 16'h0000;
            pin_sync_q <= 16'h0000;
        end
        else
        begin
            tgl_meta_q <= {wr_tgl_q, clr_tgl_q, snap_tgl_q};
            tgl_sync_q <= tgl_meta_q;
            tgl_last_q <= tgl_sync_q;
            pin_meta_q <= {ignore_link_pulses, remote_fault_in, link_pulses_ok, jabber_in,
                           mii_tx_enable_in, mii_tx_error_in, mii_tx_data_in,
                           net_rx_valid_in, net_collision_in, net_rx_data_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign snap_ev = tgl_sync_q[0] ^ tgl_last_q[0];
    assign clr_ev  = tgl_sync_q[1] ^ tgl_last_q[1];
    assign wr_ev   = tgl_sync_q[2] ^ tgl_last_q[2];

    logic       s_ignore;
    logic       s_rfault;
    logic       s_link;
    logic       s_jabber;
    logic       s_txen;
    logic       s_txer;
    logic [3:0] s_txd;
    logic       s_rxdv;
    logic       s_col;
    logic [3:0] s_rxd;

    assign {s_ignore, s_rfault, s_link, s_jabber, s_txen, s_txer, s_txd, s_rxdv, s_col, s_rxd} = pin_sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Control register

    logic [7:0] rst_cnt_q;
    logic       busy;
    logic       wrap_q;
    logic       lowpwr_q;
    logic       isolate_q;
    logic       collision_test_q;
    logic [15:0] ctrl_word;
    logic [15:0] stat_word;

    assign busy = (rst_cnt_q != 8'h00);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rst_cnt_q <= 8'h00;
        else if (busy)
            rst_cnt_q <= rst_cnt_q - 8'h01;
        else if (wr_ev && waddr_q == PGCS_ADDR_CTRL && !lowpwr_q && wdata_q[PGCS_C_RESET])
            rst_cnt_q <= RST_LOAD;
    end

    // Write data is held stable by the frame engine until the next frame
    always_ff @(posedge ref_clk)
    begin
        if (rst || busy)
        begin
            wrap_q    <= PGCS_WRAP_RST;
            lowpwr_q  <= PGCS_LOWPWR_RST;
            isolate_q <= PGCS_ISOLATE_RST;
            collision_test_q <= PGCS_COLLISION_TEST_RST;
        end
        else if (wr_ev && waddr_q == PGCS_ADDR_CTRL)
        begin
            lowpwr_q <= wdata_q[PGCS_C_LOWPWR];
            if (!lowpwr_q)
            begin
                wrap_q    <= wdata_q[PGCS_C_WRAP];
                isolate_q <= wdata_q[PGCS_C_ISOLATE];
                collision_test_q <= wdata_q[PGCS_C_COLLISION_TEST];
            end
        end
    end

    always_comb
    begin
        ctrl_word                 = 16'h0000;
        ctrl_word[PGCS_C_RESET]   = busy;
        ctrl_word[PGCS_C_WRAP]    = wrap_q;
        ctrl_word[PGCS_C_LOWPWR]  = lowpwr_q;
        ctrl_word[PGCS_C_ISOLATE] = isolate_q;
        ctrl_word[PGCS_C_COLLISION_TEST] = collision_test_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status latches; a read clears fault and jabber only if the snapshot reported them, and re-arms link on any status read

    logic rfault_q;
    logic link_q;
    logic jabber_q;

    always_ff @(posedge ref_clk)
    begin
        if (rst || busy)
        begin
            rfault_q <= 1'b0;
            jabber_q <= 1'b0;
            link_q   <= 1'b0;
        end
        else
        begin
            if (s_rfault)
                rfault_q <= 1'b1;
            else if (clr_ev && snap_stat_q[PGCS_S_RFAULT])
                rfault_q <= 1'b0;
            if (s_jabber)
                jabber_q <= 1'b1;
            else if (clr_ev && snap_stat_q[PGCS_S_JABBER])
                jabber_q <= 1'b0;
            if (!s_link)
                link_q <= 1'b0;
            else if (clr_ev || link_q)
                link_q <= 1'b1;
        end
    end

    always_comb
    begin
        stat_word                 = 16'h0000;
        stat_word[PGCS_S_RFAULT]  = rfault_q;
        stat_word[PGCS_S_LINK]    = s_ignore | link_q;
        stat_word[PGCS_S_JABBER]  = jabber_q;
        stat_word[PGCS_S_EXTCAP]  = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            snap_ctrl_q <= 16'h0000;
            snap_stat_q <= 16'h0000;
        end
        else if (snap_ev)
        begin
            snap_ctrl_q <= ctrl_word;
            snap_stat_q <= stat_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Media access state and data paths

    pgcs_mac_t mac_q;
    logic      mii_clk_q;
    logic      txen_g;

    // Isolate gates the MII transmit inputs off entirely
    assign txen_g = s_txen & ~isolate_q & ~lowpwr_q;

    always_ff @(posedge ref_clk)
    begin
        if (rst || busy || wrap_q || lowpwr_q)
            mac_q <= PGCS_MAC_INIT;
        else if (s_link || s_ignore)
            mac_q <= PGCS_MAC_RUN;
        else
            mac_q <= PGCS_MAC_INIT;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mii_clk_q             <= 1'b0;
            mii_rx_valid_out      <= 1'b0;
            mii_rx_error_out      <= 1'b0;
            mii_rx_data_out       <= 4'h0;
            mii_collision_out     <= 1'b0;
            mii_out_oe            <= 1'b0;
            net_tx_enable_out     <= 1'b0;
            net_tx_data_out       <= 4'h0;
            net_drive_en          <= 1'b0;
            oscillator_enable_out <= 1'b0;
            mac_initial_state     <= 1'b1;
        end
        else
        begin
            mii_clk_q             <= ~mii_clk_q & ~lowpwr_q;
            oscillator_enable_out <= ~lowpwr_q;
            mac_initial_state     <= (mac_q == PGCS_MAC_INIT);
            mii_out_oe            <= ~isolate_q;
            net_drive_en          <= ~wrap_q & ~lowpwr_q;
            net_tx_enable_out     <= txen_g & ~wrap_q;
            net_tx_data_out       <= (txen_g && !wrap_q) ? s_txd : 4'h0;
            if (wrap_q)
            begin
                mii_rx_valid_out <= txen_g;
                mii_rx_error_out <= txen_g & s_txer;
                mii_rx_data_out  <= txen_g ? s_txd : 4'h0;
            end
            else
            begin
                mii_rx_valid_out <= s_rxdv & ~lowpwr_q;
                mii_rx_error_out <= 1'b0;
                mii_rx_data_out  <= lowpwr_q ? 4'h0 : s_rxd;
            end
            mii_collision_out <= collision_test_q ? txen_g : (s_col & txen_g & ~wrap_q);
        end
    end

    assign mii_tx_clock_out = mii_clk_q;
    assign mii_rx_clock_out = mii_clk_q;

endmodule // pgcs_regs

// [common/pgcs_pkg.sv]
package pgcs_pkg;

    // Management register addresses
    localparam logic [4:0]  PGCS_ADDR_CTRL      = 5'h00;
    localparam logic [4:0]  PGCS_ADDR_STAT      = 5'h01;

    // Control field positions
    localparam int          PGCS_C_RESET        = 15;
    localparam int          PGCS_C_WRAP         = 14;
    localparam int          PGCS_C_LOWPWR       = 11;
    localparam int          PGCS_C_ISOLATE      = 10;
    localparam int          PGCS_C_COLLISION_TEST      = 7;

    // Status field positions
    localparam int          PGCS_S_RFAULT       = 4;
    localparam int          PGCS_S_LINK         = 2;
    localparam int          PGCS_S_JABBER       = 1;
    localparam int          PGCS_S_EXTCAP       = 0;

    // Reset values of the writable control fields
    localparam logic        PGCS_WRAP_RST       = 1'b1;
    localparam logic        PGCS_LOWPWR_RST     = 1'b1;
    localparam logic        PGCS_ISOLATE_RST    = 1'b1;
    localparam logic        PGCS_COLLISION_TEST_RST    = 1'b0;

    // Management frame encoding
    localparam logic [1:0]  PGCS_OP_READ        = 2'b10;
    localparam logic [1:0]  PGCS_OP_WRITE       = 2'b01;
    localparam logic [3:0]  PGCS_HDR_LAST       = 4'hb;
    localparam logic [3:0]  PGCS_DATA_LAST      = 4'hf;

    // Internal reset duration in ref_clk cycles
    localparam int          PGCS_RESET_CYCLES   = 16;

    typedef enum logic [2:0] {
        PGCS_MD_IDLE,
        PGCS_MD_START,
        PGCS_MD_HDR,
        PGCS_MD_TA,
        PGCS_MD_DATA
    } pgcs_md_state_t;

    typedef enum logic {
        PGCS_MAC_INIT,
        PGCS_MAC_RUN
    } pgcs_mac_t;

endpackage

// [test/pgcs_regs_chk.sv]
`timescale 1ns/10ps
module pgcs_regs_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic management_clock,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic mii_tx_clock_out,
    input wire logic mii_collision_out,
    input wire logic mii_out_oe,
    input wire logic net_tx_enable_out,
    input wire logic net_drive_en,
    input wire logic oscillator_enable_out,
    input wire logic mac_initial_state
);
    ////////////////////////////////////////////////////////////////
    reset_state_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> mac_initial_state && !oscillator_enable_out && !mii_out_oe && !net_drive_en)
        else $error("outputs not at reset state after release");
    lowpwr_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        !oscillator_enable_out [*3] |-> !net_drive_en)
        else $error("network driven while powered down");
    lowpwr_clock_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(oscillator_enable_out) |-> ##2 !mii_tx_clock_out [*4])
        else $error("transmit clock running in power down");
    wrap_holds_mac_a: assert property (@(posedge ref_clk) disable iff (rst)
        !net_drive_en [*3] |-> mac_initial_state)
        else $error("access machine left initial state while quiet");
    wrap_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(net_drive_en) |-> ##1 !net_tx_enable_out [*8])
        else $error("network transmit active while quiet");
    isolate_ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
        !mii_out_oe [*4] |-> !net_tx_enable_out && !mii_collision_out)
        else $error("transmit inputs used while isolated");
    turnaround_zero_a: assert property (@(posedge management_clock) disable iff (rst)
        $rose(mdio_oe) |-> !mdio_out)
        else $error("turnaround bit not zero");
    read_length_a: assert property (@(posedge management_clock) disable iff (rst)
        $rose(mdio_oe) |-> mdio_oe [*8] ##1 mdio_oe [*8] ##1 mdio_oe ##1 !mdio_oe)
        else $error("read answer not 17 cycles long");
endmodule // pgcs_regs_chk

bind pgcs_regs pgcs_regs_chk u_chk (
    .ref_clk(ref_clk), .rst(rst), .management_clock(management_clock),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mii_tx_clock_out(mii_tx_clock_out),
    .mii_collision_out(mii_collision_out), .mii_out_oe(mii_out_oe),
    .net_tx_enable_out(net_tx_enable_out), .net_drive_en(net_drive_en),
    .oscillator_enable_out(oscillator_enable_out), .mac_initial_state(mac_initial_state)
);

// [test/pgcs_mgmt_model.sv]
`timescale 1ns/10ps
module pgcs_mgmt_model
    import pgcs_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
)(
    output logic      management_clock,
    output logic      mdio_drv,
    output logic      mdio_drv_en,
    input  wire logic mdio_line
);
    initial
    begin
        management_clock = 1'b0;
        mdio_drv = 1'b1;
        mdio_drv_en = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Clock stands low outside frames and these idle bursts
    task automatic idle(input int n);
        repeat (n)
        begin
            #80 management_clock = 1'b1;
            #80 management_clock = 1'b0;
        end
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] regad, input logic [15:0] wdata,
                         output logic [15:0] rdata);
        logic [31:0] bits;
        bits = {2'b01, op, PHY_ADDR, regad, 2'b10, wdata};
        rdata = 16'h0000;
        for (int i = -32; i <= 32; i++)
        begin
            management_clock = 1'b0;
            // Released from turnaround on for reads; pull-up takes over
            mdio_drv_en = (i < 32) && (i < 14 || op != PGCS_OP_READ);
            mdio_drv = (i < 0 || i > 31) ? 1'b1 : bits[31 - i];
            #80;
            // Sample just before the rise, where the device's bit has stood a full period
            if (i >= 16 && i < 32)
                rdata[31 - i] = mdio_line;
            management_clock = 1'b1;
            #80;
        end
        management_clock = 1'b0;
        mdio_drv_en = 1'b0;
        #80;
    endtask
endmodule // pgcs_mgmt_model

// [test/pgcs_regs_test.sv]
`timescale 1ns/10ps
module pgcs_regs_test;
    import pgcs_pkg::*;

    localparam logic [4:0] PHY     = 5'h05;
    localparam int         RST_CYC = 100;
    localparam int         LIMIT   = 6000;

    logic        ref_clk, rst, management_clock, mdio_line, mdio_out, mdio_oe, m_drv, m_en;
    logic        ign_link, rfault, link_ok, jabber, tx_en, rx_valid;
    logic [3:0]  tx_data, rx_data, mii_rx_data_out, net_tx_data_out;
    logic        mii_tx_clock_out, mii_rx_clock_out, mii_rx_valid_out, mii_rx_error_out;
    logic        mii_collision_out, mii_out_oe, net_tx_enable_out, net_drive_en;
    logic        oscillator_enable_out, mac_initial_state;
    logic [15:0] d;
    logic [4:0]  ua [3] = '{5'h02, 5'h07, 5'h1f};
    int          n_fail = 0, n_checks = 0, cyc = 0;

    // Line has a pull-up when neither side drives
    assign mdio_line = mdio_oe ? mdio_out : (m_en ? m_drv : 1'b1);

    pgcs_regs #(.PHY_ADDR(PHY), .RESET_CYCLES(RST_CYC)) u_pgcs_regs (
        .ref_clk(ref_clk), .rst(rst), .management_clock(management_clock), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .ignore_link_pulses(ign_link),
        .remote_fault_in(rfault), .link_pulses_ok(link_ok), .jabber_in(jabber),
        .mii_tx_enable_in(tx_en), .mii_tx_data_in(tx_data), .mii_tx_error_in(1'b0),
        .net_rx_valid_in(rx_valid), .net_rx_data_in(rx_data), .net_collision_in(1'b0),
        .mii_tx_clock_out(mii_tx_clock_out), .mii_rx_clock_out(mii_rx_clock_out),
        .mii_rx_valid_out(mii_rx_valid_out), .mii_rx_error_out(mii_rx_error_out),
        .mii_rx_data_out(mii_rx_data_out), .mii_collision_out(mii_collision_out),
        .mii_out_oe(mii_out_oe), .net_tx_enable_out(net_tx_enable_out),
        .net_tx_data_out(net_tx_data_out), .net_drive_en(net_drive_en),
        .oscillator_enable_out(oscillator_enable_out), .mac_initial_state(mac_initial_state));

    pgcs_mgmt_model #(.PHY_ADDR(PHY)) u_mgmt (
        .management_clock(management_clock), .mdio_drv(m_drv), .mdio_drv_en(m_en),
        .mdio_line(mdio_line));

    initial
        ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] r;
        u_mgmt.frame(PGCS_OP_READ, a, 16'h0000, r);
        chk16(r, exp);
    endtask

    // Write lands a few ref_clk cycles after the last data bit
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        logic [15:0] r;
        u_mgmt.frame(PGCS_OP_WRITE, a, v, r);
        tick(8);
    endtask

    task automatic final_report();
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_fail++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        ign_link = 1'b0;
        rfault = 1'b0;
        link_ok = 1'b1;
        jabber = 1'b0;
        tx_en = 1'b0;
        tx_data = 4'h0;
        rx_valid = 1'b0;
        rx_data = 4'h0;
        fork
            tick(12);
            u_mgmt.idle(4);
        join
        rst = 1'b0;
        tick(2);
        chk1(mac_initial_state, 1'b1);
        chk1(oscillator_enable_out, 1'b0);
        chk1(net_drive_en, 1'b0);
        chk1(mii_out_oe, 1'b0);
        chk1(mii_rx_clock_out, 1'b0);
        rd(PGCS_ADDR_CTRL, 16'h4c00);
        u_mgmt.frame(PGCS_OP_READ, PGCS_ADDR_STAT, 16'h0000, d);
        rd(PGCS_ADDR_STAT, 16'h0005);
        foreach (ua[i])
            rd(ua[i], 16'h0000);
        wr(PGCS_ADDR_CTRL, 16'h0080);
        rd(PGCS_ADDR_CTRL, 16'h4400);
        chk1(oscillator_enable_out, 1'b1);
        wr(PGCS_ADDR_CTRL, 16'h33ff);
        rd(PGCS_ADDR_CTRL, 16'h0080);
        tx_en = 1'b1;
        tx_data = 4'h9;
        rx_data = 4'h6;
        rx_valid = 1'b1;
        tick(5);
        chk1(net_drive_en, 1'b1);
        chk1(mii_out_oe, 1'b1);
        chk1(mii_collision_out, 1'b1);
        chk1(net_tx_enable_out, 1'b1);
        chk16({12'h000, net_tx_data_out}, 16'h0009);
        chk16({12'h000, mii_rx_data_out}, 16'h0006);
        chk1(mii_rx_valid_out, 1'b1);
        chk1(mac_initial_state, 1'b0);
        d[0] = mii_rx_clock_out;
        tick(1);
        chk1(mii_rx_clock_out, !d[0]);
        tx_en = 1'b0;
        tick(5);
        chk1(mii_collision_out, 1'b0);
        wr(PGCS_ADDR_CTRL, 16'h4080);
        tx_en = 1'b1;
        tx_data = 4'h3;
        tick(8);
        chk1(net_drive_en, 1'b0);
        chk1(mac_initial_state, 1'b1);
        chk1(net_tx_enable_out, 1'b0);
        chk16({12'h000, mii_rx_data_out}, 16'h0003);
        chk1(mii_rx_valid_out, 1'b1);
        chk1(mii_rx_error_out, 1'b0);
        wr(PGCS_ADDR_CTRL, 16'h0480);
        tick(8);
        chk1(mii_out_oe, 1'b0);
        chk1(net_tx_enable_out, 1'b0);
        tx_en = 1'b0;
        rfault = 1'b1;
        jabber = 1'b1;
        link_ok = 1'b0;
        tick(4);
        rfault = 1'b0;
        jabber = 1'b0;
        link_ok = 1'b1;
        tick(6);
        rd(PGCS_ADDR_STAT, 16'h0013);
        rd(PGCS_ADDR_STAT, 16'h0005);
        ign_link = 1'b1;
        tick(4);
        link_ok = 1'b0;
        tick(6);
        rd(PGCS_ADDR_STAT, 16'h0005);
        ign_link = 1'b0;
        tick(6);
        rd(PGCS_ADDR_STAT, 16'h0001);
        link_ok = 1'b1;
        wr(PGCS_ADDR_CTRL, 16'h8000);
        chk1(mac_initial_state, 1'b1);
        rd(PGCS_ADDR_CTRL, 16'hcc00);
        tick(RST_CYC);
        rd(PGCS_ADDR_CTRL, 16'h4c00);
        chk1(oscillator_enable_out, 1'b0);
        final_report();
    end
endmodule // pgcs_regs_test
